// File: rx_delim_pkg.sv
`default_nettype none
package rx_delim_pkg;
   // Slots and format geometry
   localparam int NSLOT = 2;
   localparam int SLOT_W = 1;
   localparam int FMT_DEPTH = 16;
   localparam int SD_MAX = 5;

   // Kind of one format entry, one entry per received byte
   typedef enum logic [1:0] {
      K_DATA = 2'h0,
      K_CONST = 2'h1,
      K_SKIP = 2'h2,
      K_BCC = 2'h3
   } fmt_kind_t;

   // Receive status codes
   localparam logic [7:0] ST_IDLE = 8'h00;
   localparam logic [7:0] ST_DUP = 8'h05;
   localparam logic [7:0] ST_SD_MISS = 8'h07;
   localparam logic [7:0] ST_TIMEOUT = 8'h0b;
   localparam logic [7:0] ST_WAIT = 8'h20;
   localparam logic [7:0] ST_DONE = 8'h40;
   localparam logic [7:0] ST_DONE_VERR = 8'h4a;

   // Register offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_TIMEOUT = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h010;
   localparam logic [11:0] OFF_CFG = 12'h020;
   localparam logic [11:0] OFF_FMT = 12'h100;
   localparam logic [11:0] FMT_STRIDE = 12'h040;

   // Field positions
   localparam int CTRL_LAUNCH_LSB = 0;
   localparam int CTRL_CANCEL_LSB = 4;
   localparam int CTRL_BUSY_BIT = 8;
   localparam int CFG_ED_EN_BIT = 0;
   localparam int CFG_LEN_LSB = 8;
   localparam int FMT_KIND_LSB = 8;

   // Register select codes
   localparam logic [2:0] SEL_NONE = 3'h0;
   localparam logic [2:0] SEL_CTRL = 3'h1;
   localparam logic [2:0] SEL_TMO = 3'h2;
   localparam logic [2:0] SEL_STAT = 3'h3;
   localparam logic [2:0] SEL_CFG = 3'h4;
   localparam logic [2:0] SEL_FMT = 3'h5;

   // Character interval timeout
   localparam int CLK_MHZ = 125;
   localparam int GAP_TIMEOUT_US = 500;
   localparam logic [23:0] GAP_TIMEOUT_CYC = 24'(GAP_TIMEOUT_US * CLK_MHZ);
endpackage
`default_nettype wire

// File: sd_overlap_check.sv
`timescale 1ns/1ps
`default_nettype none
module sd_overlap_check
   import rx_delim_pkg::*;
(
   input wire logic [SD_MAX*8-1:0] sd_a, // Start delimiter bytes, first at bit 0
   input wire logic [2:0] len_a, // Its length, 0 when none
   input wire logic [SD_MAX*8-1:0] sd_b, // Second start delimiter
   input wire logic [2:0] len_b, // Its length
   output logic same // Delimiters count as equal
);
   logic [2:0] short_len;

   // Compare only as many bytes as the shorter one holds
   always_comb
   begin
      short_len = (len_a < len_b) ? len_a : len_b;
      same = (len_a != 3'h0) && (len_b != 3'h0);
      for (int i = 0; i < SD_MAX; i++)
      begin
         if (3'(i) < short_len && sd_a[i*8 +: 8] != sd_b[i*8 +: 8])
         begin
            same = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: char_gap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module char_gap_timer (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic run, // A frame is in progress
   input wire logic restart, // A character arrived
   input wire logic [23:0] limit, // Timeout in cycles
   output logic expired // One-cycle timeout pulse
);
   logic [23:0] cnt_r;
   logic armed_r;

   // Interval counter, restarted by every character
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= 24'h000000;
         armed_r <= 1'b0;
      end
      else if (restart)
      begin
         cnt_r <= 24'h000000;
         armed_r <= 1'b1;
      end
      else if (!run || expired)
      begin
         armed_r <= 1'b0;
      end
      else if (armed_r)
      begin
         cnt_r <= cnt_r + 24'h000001;
      end
   end

   assign expired = armed_r && run && !restart && (cnt_r + 24'h000001 >= limit);
endmodule
`default_nettype wire

// File: serial_receive_frame_delimiter.sv
// How it works
// - Up to five leading constants form start delimiter
// - Operations may run without any start delimiter
// - Duplicate start delimiter: second gets 5, cancelled
// - Shorter delimiter matching longer's head counts equal
// - Partial start delimiter match drops the frame
// - Gap timer runs from first byte; timeout gives 11
// - Constants after data, skip or check excluded
// - Other constants are compared against received bytes
// - Launch of an inactive operation sets status 32, or 5 if duplicate
// - End delimiter: one constant byte, placed last or just before a final check byte
// - End delimiter byte ends frame data early
// - No end delimiter: finish on format byte count
// - Interval timeout ends reception in every mode
// - End delimiter not stored; later bytes dropped
// - Check byte after end delimiter taken, not stored
// - Any number of verification constants, result in status
// - Clean completion shows status 64
// - Verification mismatch completes with status 74
// - Start delimiter mismatch records 7, keeps waiting
// - Start delimiter bytes are never stored
`timescale 1ns/1ps
`default_nettype none
module serial_receive_frame_delimiter #(
   parameter logic [23:0] TIMEOUT_CYCLES = rx_delim_pkg::GAP_TIMEOUT_CYC
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic rx_valid, // Received byte strobe
   input wire logic [7:0] rx_data, // Received byte
   output logic store_valid, // Data byte for a data register
   output logic [rx_delim_pkg::SLOT_W-1:0] store_slot, // Operation owning it
   output logic [4:0] store_index, // Format position of the byte
   output logic [7:0] store_data, // The byte itself
   output logic [rx_delim_pkg::NSLOT-1:0] op_done // Completion pulse per operation
);
   import rx_delim_pkg::*;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_HUNT = 5'b00010,
      S_BODY = 5'b00100,
      S_TAIL = 5'b01000,
      S_DRAIN = 5'b10000
   } eng_state_t;

   // Configuration and per-operation state
   logic [NSLOT-1:0][FMT_DEPTH-1:0][9:0] fmt_r;
   logic [NSLOT-1:0][4:0] flen_r;
   logic [NSLOT-1:0] ed_en_r;
   logic [NSLOT-1:0] active_r;
   logic [NSLOT-1:0][7:0] status_r;
   logic [23:0] timeout_r;
   logic [31:0] prdata_r;

   // Derived per-operation format facts
   logic [NSLOT-1:0][4:0] ed_pos;
   logic [NSLOT-1:0][4:0] body_end;
   logic [NSLOT-1:0][2:0] sd_len;
   logic [NSLOT-1:0][SD_MAX*8-1:0] sd_bytes;
   logic [NSLOT-1:0] bcc_after;
   logic [NSLOT-1:0] has_sd;

   // Engine
   eng_state_t state_r, state_nxt;
   logic [SLOT_W-1:0] owner_r, owner_nxt;
   logic [4:0] pos_r, pos_nxt;
   logic [NSLOT-1:0] mask_r, mask_nxt;
   logic [2:0] hidx_r, hidx_nxt;
   logic verr_r, verr_nxt;
   logic [NSLOT-1:0] fin_mask, tmo_mask, miss_mask, own_oh;
   logic take_body, tmo;

   // Byte step signals
   logic [SLOT_W-1:0] cur_slot;
   logic [4:0] cur_pos, nxt_pos;
   logic [9:0] entry;
   logic hit_ed, step_store, step_verr, step_tail, step_fin;

   // Start delimiter hunt signals
   logic [NSLOT-1:0] cand, still, complete;
   logic [2:0] hidx;
   logic [SLOT_W-1:0] done_slot, nosd_slot;
   logic nosd_any;

   // Bus decode
   logic [2:0] sel;
   logic [SLOT_W-1:0] sel_slot;
   logic wr;
   logic [NSLOT-1:0] launch, cancel, dup;
   logic same_sd;

   function automatic logic [2:0] reg_sel(input logic [11:0] a);
      reg_sel = SEL_NONE;
      if (a == OFF_CTRL)
         reg_sel = SEL_CTRL;
      else if (a == OFF_TIMEOUT)
         reg_sel = SEL_TMO;
      else if (a[11:4] == OFF_STATUS[11:4] && int'(a[3:2]) < NSLOT)
         reg_sel = SEL_STAT;
      else if (a[11:4] == OFF_CFG[11:4] && int'(a[3:2]) < NSLOT)
         reg_sel = SEL_CFG;
      else if (a[11:8] == OFF_FMT[11:8] && int'(a[7:6]) < NSLOT)
         reg_sel = SEL_FMT;
   endfunction

   function automatic logic [1:0] kind_of(input logic [9:0] e);
      kind_of = e[FMT_KIND_LSB +: 2];
   endfunction

   // Format analysis for each operation
   for (genvar s = 0; s < NSLOT; s++)
   begin : g_fmt
      logic [4:0] last;
      logic run;
      always_comb
      begin
         last = flen_r[s] - 5'h01;
         ed_pos[s] = last;
         bcc_after[s] = 1'b0;
         if (flen_r[s] > 5'h01 && kind_of(fmt_r[s][last[3:0]]) == K_BCC
             && kind_of(fmt_r[s][last[3:0] - 4'h1]) == K_CONST)
         begin
            ed_pos[s] = last - 5'h01;
            bcc_after[s] = ed_en_r[s];
         end
         body_end[s] = ed_en_r[s] ? ed_pos[s] : flen_r[s];
         sd_len[s] = 3'h0;
         run = 1'b1;
         for (int i = 0; i < SD_MAX; i++)
         begin
            sd_bytes[s][i*8 +: 8] = fmt_r[s][i][7:0];
            if (run && 5'(i) < body_end[s] && kind_of(fmt_r[s][i]) == K_CONST)
               sd_len[s] = sd_len[s] + 3'h1;
            else
               run = 1'b0;
         end
         has_sd[s] = sd_len[s] != 3'h0;
      end
   end

   sd_overlap_check u_overlap (
      .sd_a(sd_bytes[0]),
      .len_a(sd_len[0]),
      .sd_b(sd_bytes[1]),
      .len_b(sd_len[1]),
      .same(same_sd)
   );

   char_gap_timer u_gap (
      .pclk(pclk),
      .presetn(presetn),
      .run(state_r != S_IDLE),
      .restart(rx_valid),
      .limit(timeout_r),
      .expired(tmo)
   );

   // Bus decode and launch commands
   assign sel = reg_sel(paddr);
   assign sel_slot = (sel == SEL_FMT) ? paddr[6 +: SLOT_W] : paddr[2 +: SLOT_W];
   assign wr = psel && penable && pwrite && sel != SEL_NONE;
   assign launch = (wr && sel == SEL_CTRL) ? pwdata[CTRL_LAUNCH_LSB +: NSLOT] : '0;
   assign cancel = (wr && sel == SEL_CTRL) ? pwdata[CTRL_CANCEL_LSB +: NSLOT] : '0;
   assign dup[0] = same_sd && active_r[1];
   assign dup[1] = same_sd && (active_r[0] || launch[0]);
   assign pready = 1'b1;
   assign pslverr = psel && penable && sel == SEL_NONE;
   assign prdata = prdata_r;

   // Configuration writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fmt_r <= '0;
         flen_r <= '0;
         ed_en_r <= '0;
         timeout_r <= TIMEOUT_CYCLES;
      end
      else if (wr)
      begin
         if (sel == SEL_FMT)
            fmt_r[sel_slot][paddr[5:2]] <= pwdata[9:0];
         if (sel == SEL_CFG)
         begin
            flen_r[sel_slot] <= pwdata[CFG_LEN_LSB +: 5];
            ed_en_r[sel_slot] <= pwdata[CFG_ED_EN_BIT];
         end
         if (sel == SEL_TMO)
            timeout_r <= pwdata[23:0];
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= 32'h00000000;
      else if (psel && !penable)
      begin
         prdata_r <= 32'h00000000;
         unique case (sel)
            SEL_CTRL: prdata_r <= {23'h000000, state_r != S_IDLE, 6'h00, active_r};
            SEL_TMO: prdata_r <= {8'h00, timeout_r};
            SEL_STAT: prdata_r <= {24'h000000, status_r[sel_slot]};
            SEL_CFG: prdata_r <= {19'h00000, flen_r[sel_slot], 7'h00, ed_en_r[sel_slot]};
            SEL_FMT: prdata_r <= {22'h000000, fmt_r[sel_slot][paddr[5:2]]};
            default: prdata_r <= 32'h00000000;
         endcase
      end
   end

   // Start delimiter hunt and fallback owner
   always_comb
   begin
      cand = (state_r == S_IDLE) ? (active_r & has_sd) : mask_r;
      hidx = (state_r == S_IDLE) ? 3'h0 : hidx_r;
      done_slot = '0;
      nosd_slot = '0;
      nosd_any = 1'b0;
      for (int s = NSLOT - 1; s >= 0; s--)
      begin
         still[s] = cand[s] && fmt_r[s][hidx][7:0] == rx_data;
         complete[s] = still[s] && (hidx + 3'h1) == sd_len[s];
         if (complete[s])
            done_slot = SLOT_W'(s);
         if (active_r[s] && !has_sd[s])
         begin
            nosd_slot = SLOT_W'(s);
            nosd_any = 1'b1;
         end
      end
   end

   // One byte of frame body against the format
   always_comb
   begin
      cur_slot = (state_r == S_IDLE) ? nosd_slot : owner_r;
      cur_pos = (state_r == S_IDLE) ? 5'h00 : pos_r;
      nxt_pos = cur_pos + 5'h01;
      entry = fmt_r[cur_slot][cur_pos[3:0]];
      hit_ed = ed_en_r[cur_slot] && rx_data == fmt_r[cur_slot][ed_pos[cur_slot][3:0]][7:0];
      step_store = !hit_ed && kind_of(entry) == K_DATA;
      step_verr = !hit_ed && kind_of(entry) == K_CONST && entry[7:0] != rx_data;
      step_tail = hit_ed && bcc_after[cur_slot];
      step_fin = hit_ed ? !bcc_after[cur_slot] : (nxt_pos >= body_end[cur_slot]);
      own_oh = NSLOT'(1) << owner_r;
   end

   // Engine next state
   always_comb
   begin
      state_nxt = state_r;
      owner_nxt = owner_r;
      pos_nxt = pos_r;
      mask_nxt = mask_r;
      hidx_nxt = hidx_r;
      verr_nxt = verr_r;
      fin_mask = '0;
      tmo_mask = '0;
      miss_mask = '0;
      take_body = 1'b0;
      unique case (state_r)
         S_IDLE:
            if (rx_valid)
            begin
               verr_nxt = 1'b0;
               if (|complete)
               begin
                  owner_nxt = done_slot;
                  pos_nxt = {2'h0, sd_len[done_slot]};
                  state_nxt = S_BODY;
               end
               else if (|still)
               begin
                  mask_nxt = still;
                  hidx_nxt = 3'h1;
                  state_nxt = S_HUNT;
               end
               else if (nosd_any)
               begin
                  owner_nxt = nosd_slot;
                  take_body = 1'b1;
               end
               else
               begin
                  miss_mask = cand;
                  state_nxt = S_DRAIN;
               end
            end
         S_HUNT:
            if (tmo)
            begin
               tmo_mask = mask_r;
               state_nxt = S_IDLE;
            end
            else if (rx_valid)
            begin
               if (|complete)
               begin
                  owner_nxt = done_slot;
                  pos_nxt = {2'h0, sd_len[done_slot]};
                  state_nxt = S_BODY;
               end
               else if (|still)
               begin
                  mask_nxt = still;
                  hidx_nxt = hidx_r + 3'h1;
               end
               else
               begin
                  miss_mask = mask_r;
                  state_nxt = S_DRAIN;
               end
            end
         S_BODY:
            if (tmo)
            begin
               tmo_mask = own_oh;
               state_nxt = S_IDLE;
            end
            else if (rx_valid)
               take_body = 1'b1;
         S_TAIL:
            if (tmo)
            begin
               tmo_mask = own_oh;
               state_nxt = S_IDLE;
            end
            else if (rx_valid)
            begin
               fin_mask = own_oh;
               state_nxt = S_DRAIN;
            end
         S_DRAIN:
            if (tmo)
               state_nxt = S_IDLE;
         default:
            state_nxt = S_IDLE;
      endcase
      if (take_body)
      begin
         verr_nxt = verr_nxt | step_verr;
         pos_nxt = nxt_pos;
         if (step_tail)
            state_nxt = S_TAIL;
         else if (step_fin)
         begin
            fin_mask = NSLOT'(1) << cur_slot;
            state_nxt = S_DRAIN;
         end
         else
            state_nxt = S_BODY;
      end
   end

   // Engine registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= S_IDLE;
         owner_r <= '0;
         pos_r <= 5'h00;
         mask_r <= '0;
         hidx_r <= 3'h0;
         verr_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         owner_r <= owner_nxt;
         pos_r <= pos_nxt;
         mask_r <= mask_nxt;
         hidx_r <= hidx_nxt;
         verr_r <= verr_nxt;
      end
   end

   // Store port for data bytes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         store_valid <= 1'b0;
         store_slot <= '0;
         store_index <= 5'h00;
         store_data <= 8'h00;
      end
      else
      begin
         store_valid <= take_body && step_store && active_r[cur_slot];
         if (take_body && step_store)
         begin
            store_slot <= cur_slot;
            store_index <= cur_pos;
            store_data <= rx_data;
         end
      end
   end

   // Status words, activity and completion pulses
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_r <= '0;
         active_r <= '0;
         op_done <= '0;
      end
      else
      begin
         for (int s = 0; s < NSLOT; s++)
         begin
            op_done[s] <= fin_mask[s] && active_r[s];
            if (fin_mask[s] && active_r[s])
            begin
               status_r[s] <= verr_nxt ? ST_DONE_VERR : ST_DONE;
               active_r[s] <= 1'b0;
            end
            else if (tmo_mask[s] && active_r[s])
            begin
               status_r[s] <= ST_TIMEOUT;
               active_r[s] <= 1'b0;
            end
            else if (miss_mask[s] && active_r[s])
               status_r[s] <= ST_SD_MISS;
            else if (launch[s] && !active_r[s])
            begin
               status_r[s] <= dup[s] ? ST_DUP : ST_WAIT;
               active_r[s] <= !dup[s];
            end
            else if (cancel[s])
               active_r[s] <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: serial_receive_frame_delimiter_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rx_frame_checker #(
   parameter logic [23:0] TIMEOUT_CYCLES = rx_delim_pkg::GAP_TIMEOUT_CYC
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [11:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic rx_valid, // Byte strobe
   input wire logic [7:0] rx_data, // Received byte
   input wire logic store_valid, // Stored byte strobe
   input wire logic [rx_delim_pkg::SLOT_W-1:0] store_slot, // Owning operation
   input wire logic [4:0] store_index, // Format position
   input wire logic [7:0] store_data, // Stored byte
   input wire logic [rx_delim_pkg::NSLOT-1:0] op_done // Completion pulses
);
   import rx_delim_pkg::*;
   // Address with no register behind it
   localparam logic [11:0] HOLE = 12'h008;
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Bus answers
   chk_ready_high: assert property (pready)
      else $error("pready low");
   chk_err_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   chk_err_unmapped: assert property (psel && penable && paddr == HOLE |-> pslverr)
      else $error("unmapped access not refused");
   chk_zero_unmapped: assert property (psel && penable && !pwrite && paddr == HOLE |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_status_mapped: assert property (psel && penable && paddr == OFF_STATUS |-> !pslverr)
      else $error("status access refused");
   // Byte path
   chk_store_cause: assert property (store_valid |-> $past(rx_valid))
      else $error("store without a byte");
   chk_store_byte: assert property (store_valid |-> store_data == $past(rx_data))
      else $error("stored byte differs");
   chk_store_index: assert property (store_valid |-> store_index < 5'(FMT_DEPTH))
      else $error("store index out of format");
   chk_done_cause: assert property (op_done != 2'h0 |-> $past(rx_valid))
      else $error("completion without a byte");
   chk_done_pulse: assert property (op_done != 2'h0 |=> (op_done & $past(op_done)) == 2'h0)
      else $error("completion pulse too long");
endmodule
bind serial_receive_frame_delimiter rx_frame_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .rx_valid, .rx_data, .store_valid, .store_slot, .store_index, .store_data, .op_done
);
`default_nettype wire

// File: remote_station.sv
`timescale 1ns/1ps
`default_nettype none
module remote_station (
   input wire logic pclk, // System clock
   output logic rx_valid, // Byte strobe
   output logic [7:0] rx_data // Byte on the line
);
   // Quiet line at start
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
   end
   // One byte, then the line shows the inverse so stale data never matches
   task automatic send(input logic [7:0] b);
      rx_valid <= 1'b1;
      rx_data <= b;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_data <= ~b;
      repeat (3) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// File: serial_receive_frame_delimiter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_receive_frame_delimiter_bench;
   import rx_delim_pkg::*;
   localparam logic [23:0] TMO = 24'h000014;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, store_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] rx_data, store_data, last_d;
   logic [SLOT_W-1:0] store_slot, last_s;
   logic [4:0] store_index, last_i;
   logic [NSLOT-1:0] op_done;
   int error_cnt, comparisons, stores, cyc, s0, done0, done1;
   // Clock
   initial pclk = 1'b0;
   always #4 pclk = ~pclk;
   serial_receive_frame_delimiter #(.TIMEOUT_CYCLES(TMO)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_data(rx_data), .store_valid(store_valid), .store_slot(store_slot),
      .store_index(store_index), .store_data(store_data), .op_done(op_done)
   );
   remote_station tx_u (
      .pclk(pclk),
      .rx_valid(rx_valid),
      .rx_data(rx_data)
   );
   // Stored byte monitor
   always @(posedge pclk)
   begin
      if (store_valid === 1'b1)
      begin
         stores <= stores + 1;
         last_d <= store_data;
         last_i <= store_index;
         last_s <= store_slot;
      end
      if (op_done[0] === 1'b1)
         done0 <= done0 + 1;
      if (op_done[1] === 1'b1)
         done1 <= done1 + 1;
   end
   // Hang guard
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         error_cnt = error_cnt + 1;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      comparisons = comparisons + 1;
      if (s !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("Error at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   // APB transfer, started right after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge, so a following setup never reassigns psel in this step
      @(posedge pclk);
   endtask
   task automatic st(input int op, input logic [7:0] e);
      apb(1'b0, 12'(OFF_STATUS + 4 * op), 32'h0);
      check(rd, {24'h0, e});
   endtask
   // Load a format and its settings
   task automatic cfg(input int op, input logic ed, input logic [9:0] e[$]);
      foreach (e[i]) apb(1'b1, 12'(OFF_FMT + FMT_STRIDE * op + 4 * i), {22'h0, e[i]});
      apb(1'b1, 12'(OFF_CFG + 4 * op), (32'(e.size()) << 8) | 32'(ed));
   endtask
   task automatic frm(input logic [7:0] b[$]);
      foreach (b[i]) tx_u.send(b[i]);
      repeat (2) @(posedge pclk);
   endtask
   // Let the drain period run out
   task automatic idle();
      repeat (30) @(posedge pclk);
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, OFF_TIMEOUT, 32'h0);
      check(rd, 32'(TMO));
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h0);
      // Two-byte start delimiter, early end delimiter
      cfg(0, 1'b1, {10'h102, 10'h131, 10'h000, 10'h000, 10'h103});
      apb(1'b1, OFF_CTRL, 32'h1);
      st(0, ST_WAIT);
      frm({8'h02, 8'h31, 8'h41, 8'h03});
      st(0, ST_DONE);
      check(32'(stores), 32'h1);
      check({24'h0, last_d}, 32'h41);
      check({27'h0, last_i}, 32'h2);
      frm({8'h55});
      check(32'(stores), 32'h1);
      idle();
      // Duplicate launch with a shorter delimiter
      apb(1'b1, OFF_CTRL, 32'h1);
      cfg(1, 1'b1, {10'h102, 10'h000, 10'h103});
      apb(1'b1, OFF_CTRL, 32'h2);
      st(1, ST_DUP);
      apb(1'b0, OFF_CTRL, 32'h0);
      check(rd & 32'h3, 32'h1);
      // Partial delimiter, then a good frame
      frm({8'h02, 8'h35});
      st(0, ST_SD_MISS);
      idle();
      frm({8'h02, 8'h31, 8'h41, 8'h03});
      st(0, ST_DONE);
      idle();
      // Gap inside the start delimiter
      apb(1'b1, OFF_CTRL, 32'h1);
      frm({8'h02});
      idle();
      st(0, ST_TIMEOUT);
      // Constant after data is a verification constant
      cfg(0, 1'b1, {10'h102, 10'h000, 10'h131, 10'h000, 10'h103});
      apb(1'b1, OFF_CTRL, 32'h1);
      frm({8'h02, 8'h41, 8'h39, 8'h42, 8'h03});
      st(0, ST_DONE_VERR);
      idle();
      // No delimiters: byte count with a skip
      cfg(1, 1'b0, {10'h000, 10'h200, 10'h000});
      s0 = stores;
      apb(1'b1, OFF_CTRL, 32'h2);
      frm({8'h41, 8'h42, 8'h43});
      st(1, ST_DONE);
      check(32'(stores - s0), 32'h2);
      check({31'h0, last_s}, 32'h1);
      idle();
      // Check byte after the end delimiter
      cfg(1, 1'b1, {10'h102, 10'h000, 10'h000, 10'h1ff, 10'h300});
      apb(1'b1, OFF_CTRL, 32'h2);
      frm({8'h02, 8'h41, 8'hff});
      st(1, ST_WAIT);
      s0 = stores;
      frm({8'h77});
      st(1, ST_DONE);
      check(32'(stores - s0), 32'h0);
      check(32'(done0), 32'h3);
      check(32'(done1), 32'h2);
      // Cancel of a waiting operation while the engine still drains
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_CTRL, 32'h10);
      apb(1'b0, OFF_CTRL, 32'h0);
      check(rd & 32'h103, 32'h100);
      finish_test();
   end
endmodule
`default_nettype wire
